// ---- rtl/rcs_pkg.sv ----
// Constants for the receive control two / transmit space register bank.
// Assumes a register access port on the device system clock.
`default_nettype none
package rcs_pkg;
  // Register offsets (byte addresses of the 16-bit registers)
  localparam logic [7:0] RCS_OFF_RX_CTRL_TWO = 8'h76;
  localparam logic [7:0] RCS_OFF_TX_SPACE    = 8'h78;
  localparam logic [7:0] RCS_OFF_RESV_LO     = 8'h7A;
  localparam logic [7:0] RCS_OFF_RESV_HI     = 8'h7B;
  // Field positions in receive_control_two
  localparam int RCS_BURST_HI    = 7;
  localparam int RCS_BURST_LO    = 5;
  localparam int RCS_FRAG_BIT    = 4;
  localparam int RCS_ZERO_BIT    = 3;
  localparam int RCS_LITE_BIT    = 2;
  localparam int RCS_ICMP_BIT    = 1;
  localparam int RCS_SELF_BIT    = 0;
  // Reset values
  localparam logic [2:0] RCS_BURST_RST = 3'h0;
  localparam logic [4:0] RCS_FLAGS_RST = 5'h04;
  // Burst codes
  localparam logic [2:0] RCS_BURST_4     = 3'h0;
  localparam logic [2:0] RCS_BURST_8     = 3'h1;
  localparam logic [2:0] RCS_BURST_16    = 3'h2;
  localparam logic [2:0] RCS_BURST_32    = 3'h3;
  localparam logic [2:0] RCS_BURST_FRAME = 3'h4;
  // Burst sizes in bytes; zero means whole frame
  localparam logic [5:0] RCS_BYTES_4  = 6'h04;
  localparam logic [5:0] RCS_BYTES_8  = 6'h08;
  localparam logic [5:0] RCS_BYTES_16 = 6'h10;
  localparam logic [5:0] RCS_BYTES_32 = 6'h20;
  localparam logic [5:0] RCS_BYTES_FRAME = 6'h00;
  // Free-byte field width
  localparam int RCS_FREE_W = 13;
endpackage
`default_nettype wire

// ---- rtl/rcs_regs.sv ----
// Receive control two and transmit space registers.
// Assumes a 16-bit register port and a queue unit reporting usage.
//
// What this block and its host do
// RQ1 - Burst field codes 000..100 map to 4, 8, 16, 32 bytes or a whole frame.
// RQ2 - The host never writes the reserved burst codes 101 to 111.
// RQ3 - The host sends a queue read command byte before every burst.
// RQ4 - Burst field sits in bits 7..5, is write-only and resets to zero.
// RQ5 - With fragment-pass set, fragmented UDP frames pass the checksum check.
// RQ6 - With fragment-pass clear, fragmented UDP frames are checked like others.
// RQ7 - With zero-checksum pass set, UDP frames with checksum zero are accepted.
// RQ8 - With zero-checksum pass clear, UDP frames with checksum zero are dropped.
// RQ9 - With UDP-Lite enable set (reset 1), UDP-Lite is checked and generated.
// RQ10 - With UDP-Lite enable clear, UDP-Lite passes and no checksum is generated.
// RQ11 - With ICMP check set, bad-checksum unfragmented ICMP frames are dropped.
// RQ12 - With self filter set, frames whose source is the station address drop.
// RQ13 - The transmit space register shows free bytes in bits 12..0, rest zero.
// RQ14 - Free bytes count both payload and per-frame control words.
// RQ15 - The host checks free bytes cover a whole frame before writing it.
// RQ16 - Reserved bits and the reserved range read zero and ignore writes.
`default_nettype none
module rcs_regs #(
  parameter int MEM_BYTES = 6144
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // Transmit queue usage
  input  wire logic [12:0] tx_payload_used_i,
  input  wire logic [12:0] tx_ctrl_used_i,
  // Receive frame classification
  input  wire logic        rx_frame_done_i,
  input  wire logic        rx_is_udp_i,
  input  wire logic        rx_is_udp_lite_i,
  input  wire logic        rx_is_icmp_i,
  input  wire logic        rx_is_fragment_i,
  input  wire logic        rx_csum_bad_i,
  input  wire logic        rx_udp_csum_zero_i,
  input  wire logic [47:0] rx_src_addr_i,
  input  wire logic [47:0] station_address_i,
  // Transmit frame class
  input  wire logic        tx_is_udp_lite_i,
  // Results
  output logic             rx_drop_o,
  output logic             tx_lite_csum_gen_o,
  output logic      [5:0]  rx_burst_bytes_o,
  output logic             rx_burst_frame_o
);

  // Refuse memory sizes that the free-byte field cannot show
  if (MEM_BYTES < 1 || MEM_BYTES > (1 << rcs_pkg::RCS_FREE_W) - 1) begin : g_mem_check
    $error("MEM_BYTES out of range");
  end

  localparam logic [13:0] MEM_SIZE = 14'(MEM_BYTES);

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  logic [2:0] burst_reg;
  logic [2:0] burst_next;
  logic [4:0] flags_reg;
  logic [4:0] flags_next;
  logic       wr_ctrl;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == rcs_pkg::RCS_OFF_RX_CTRL_TWO);

  // Next values of control fields
  always_comb begin
    burst_next = burst_reg;
    flags_next = flags_reg;
    if (wr_ctrl) begin
      burst_next = reg_wdata_i[rcs_pkg::RCS_BURST_HI:rcs_pkg::RCS_BURST_LO]; // [RQ4]
      flags_next = reg_wdata_i[rcs_pkg::RCS_FRAG_BIT:rcs_pkg::RCS_SELF_BIT];
    end
  end

  // Control registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_reg <= rcs_pkg::RCS_BURST_RST; // [RQ4]
      flags_reg <= rcs_pkg::RCS_FLAGS_RST; // [RQ9]
    end else begin
      burst_reg <= burst_next;
      flags_reg <= flags_next;
    end
  end

  logic frag_pass;
  logic zero_pass;
  logic lite_en;
  logic icmp_en;
  logic self_en;
  assign frag_pass = flags_reg[rcs_pkg::RCS_FRAG_BIT];
  assign zero_pass = flags_reg[rcs_pkg::RCS_ZERO_BIT];
  assign lite_en   = flags_reg[rcs_pkg::RCS_LITE_BIT];
  assign icmp_en   = flags_reg[rcs_pkg::RCS_ICMP_BIT];
  assign self_en   = flags_reg[rcs_pkg::RCS_SELF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Burst size decode
  logic [5:0] bytes_next;
  logic       frame_next;
  logic [5:0] bytes_reg;
  logic       frame_reg;

  // Code to byte count; reserved codes fall back to four bytes
  always_comb begin
    frame_next = 1'b0;
    case (burst_reg) // [RQ1]
      rcs_pkg::RCS_BURST_8:     bytes_next = rcs_pkg::RCS_BYTES_8;
      rcs_pkg::RCS_BURST_16:    bytes_next = rcs_pkg::RCS_BYTES_16;
      rcs_pkg::RCS_BURST_32:    bytes_next = rcs_pkg::RCS_BYTES_32;
      rcs_pkg::RCS_BURST_FRAME: begin
        bytes_next = rcs_pkg::RCS_BYTES_FRAME;
        frame_next = 1'b1;
      end
      default:                  bytes_next = rcs_pkg::RCS_BYTES_4; // [RQ2]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive drop decision
  logic drop_next;
  logic drop_reg;
  logic lite_gen_next;
  logic lite_gen_reg;

  // Checksum and self-address policy per finished frame
  always_comb begin
    drop_next = 1'b0;
    if (rx_frame_done_i) begin
      if (self_en && (rx_src_addr_i == station_address_i)) begin
        drop_next = 1'b1; // [RQ12]
      end else if (rx_is_udp_i && rx_is_fragment_i && frag_pass) begin
        drop_next = 1'b0; // [RQ5]
      end else if (rx_is_udp_i && rx_udp_csum_zero_i) begin
        drop_next = !zero_pass; // [RQ7] [RQ8]
      end else if (rx_is_udp_lite_i) begin
        drop_next = lite_en && rx_csum_bad_i; // [RQ9] [RQ10]
      end else if (rx_is_icmp_i) begin
        drop_next = icmp_en && !rx_is_fragment_i && rx_csum_bad_i; // [RQ11]
      end else if (rx_is_udp_i) begin
        drop_next = rx_csum_bad_i; // [RQ6]
      end
    end
    lite_gen_next = tx_is_udp_lite_i && lite_en; // [RQ9] [RQ10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-byte count
  logic [13:0] used_sum;
  logic [12:0] free_next;
  logic [12:0] free_reg;

  // Payload plus control words both consume memory
  always_comb begin
    used_sum = {1'b0, tx_payload_used_i} + {1'b0, tx_ctrl_used_i}; // [RQ14]
    if (used_sum >= MEM_SIZE) begin
      free_next = '0;
    end else begin
      free_next = 13'(MEM_SIZE - used_sum);
    end
  end

  // Result registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bytes_reg    <= rcs_pkg::RCS_BYTES_4;
      frame_reg    <= 1'b0;
      drop_reg     <= 1'b0;
      lite_gen_reg <= 1'b0;
      free_reg     <= '0;
    end else begin
      bytes_reg    <= bytes_next;
      frame_reg    <= frame_next;
      drop_reg     <= drop_next;
      lite_gen_reg <= lite_gen_next;
      free_reg     <= free_next; // [RQ13]
    end
  end

  assign rx_burst_bytes_o   = bytes_reg;
  assign rx_burst_frame_o   = frame_reg;
  assign rx_drop_o          = drop_reg;
  assign tx_lite_csum_gen_o = lite_gen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [15:0] rdata_next;
  logic [15:0] rdata_reg;

  // Burst field is write-only and reads zero
  always_comb begin
    rdata_next = '0;
    if (reg_rd_i && reg_addr_i == rcs_pkg::RCS_OFF_RX_CTRL_TWO) begin
      rdata_next = {11'h000, flags_reg}; // [RQ16]
    end else if (reg_rd_i && reg_addr_i == rcs_pkg::RCS_OFF_TX_SPACE) begin
      rdata_next = {3'h0, free_reg}; // [RQ13]
    end else if (reg_rd_i && (reg_addr_i == rcs_pkg::RCS_OFF_RESV_LO ||
                              reg_addr_i == rcs_pkg::RCS_OFF_RESV_HI)) begin
      rdata_next = '0; // [RQ16]
    end
  end

  // Read data register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_ctrl_write;
    reg_wr_i && reg_addr_i == rcs_pkg::RCS_OFF_RX_CTRL_TWO;
  endsequence

  a_burst_decode: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ1]
    (s_ctrl_write and
     reg_wdata_i[rcs_pkg::RCS_BURST_HI:rcs_pkg::RCS_BURST_LO] == rcs_pkg::RCS_BURST_32)
      |-> ##2 rx_burst_bytes_o == rcs_pkg::RCS_BYTES_32)
    else $error("burst code 3 not 32 bytes");

  a_frame_burst: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ1]
    (s_ctrl_write and
     reg_wdata_i[rcs_pkg::RCS_BURST_HI:rcs_pkg::RCS_BURST_LO] == rcs_pkg::RCS_BURST_FRAME)
      |-> ##2 rx_burst_frame_o)
    else $error("burst code 4 not whole frame");

  a_burst_wo: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ4]
    reg_rd_i && reg_addr_i == rcs_pkg::RCS_OFF_RX_CTRL_TWO |=> reg_rdata_o[15:5] == '0)
    else $error("burst or reserved bits readable");

  a_flag_readback: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ5]
    s_ctrl_write ##1 !reg_wr_i
      ##1 (reg_rd_i && reg_addr_i == rcs_pkg::RCS_OFF_RX_CTRL_TWO && !reg_wr_i)
      |=> reg_rdata_o[rcs_pkg::RCS_FRAG_BIT:rcs_pkg::RCS_SELF_BIT] ==
          $past(reg_wdata_i[rcs_pkg::RCS_FRAG_BIT:rcs_pkg::RCS_SELF_BIT], 3))
    else $error("flags not stored");

  a_zero_drop: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ8]
    rx_frame_done_i && !self_en && rx_is_udp_i && !rx_is_fragment_i && rx_udp_csum_zero_i
      && !zero_pass |=> rx_drop_o)
    else $error("zero checksum udp not dropped");

  a_self_drop: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ12]
    rx_frame_done_i && self_en && rx_src_addr_i == station_address_i |=> rx_drop_o)
    else $error("own source not dropped");

  a_lite_gen: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ10]
    tx_is_udp_lite_i && !lite_en |=> !tx_lite_csum_gen_o)
    else $error("lite checksum generated while off");

  a_icmp_drop: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ11]
    rx_frame_done_i && !self_en && rx_is_icmp_i && !rx_is_udp_i && !rx_is_udp_lite_i
      && icmp_en && !rx_is_fragment_i && rx_csum_bad_i |=> rx_drop_o)
    else $error("bad icmp not dropped");

  a_free_count: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ14]
    14'(tx_payload_used_i) + 14'(tx_ctrl_used_i) < MEM_SIZE
      |=> 14'(free_reg) + $past(14'(tx_payload_used_i))
          + $past(14'(tx_ctrl_used_i)) == MEM_SIZE)
    else $error("free count wrong");

  a_free_floor: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RQ13]
    14'(tx_payload_used_i) + 14'(tx_ctrl_used_i) >= MEM_SIZE |=> free_reg == '0)
    else $error("free count not floored at zero");

endmodule
`default_nettype wire

// ---- tb/rcs_host_model.sv ----
// Host model that drives the register port of the control bank.
// Assumes the bench calls its tasks; pins change 1 ns after a rising edge.
`default_nettype none
module rcs_host_model (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] reg_rdata_i,
  output var  logic        reg_wr_o,
  output var  logic        reg_rd_o,
  output var  logic [7:0]  reg_addr_o,
  output var  logic [15:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle port at time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Write pulse; reserved burst codes are never sent
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i) #1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = (a != 8'h76) || (d[7:5] <= 3'h4);
    @(posedge core_clk_i) #1;
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask
  // Read pulse; data is taken in the cycle after the strobe
  // Queue bursts would each follow a read command byte; none pass here
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge core_clk_i) #1;
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(posedge core_clk_i) #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    q          = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the receive control two / transmit space bank.
// Assumes rcs_regs and rcs_host_model; 40 MHz clock, active-low reset.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MEM = 1000;
  logic        core_clk_i, rst_b_i, wr, rd, done, same, lite_tx, drop, gen, frm;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, q;
  logic [12:0] pay, ctl;
  logic [5:0]  cls, bytes;
  logic [47:0] src;
  logic [5:0]  bt [5] = '{6'h04, 6'h08, 6'h10, 6'h20, 6'h00};
  int          fails, n_tests;
  assign src = same ? 48'h0A0B0C0D0E0F : 48'h0A0B0C0D0E10;
  rcs_host_model rcs_host_model_inst (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
  rcs_regs #(.MEM_BYTES(MEM)) rcs_regs_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .tx_payload_used_i(pay), .tx_ctrl_used_i(ctl),
    .rx_frame_done_i(done), .rx_is_udp_i(cls[5]), .rx_is_udp_lite_i(cls[4]),
    .rx_is_icmp_i(cls[3]), .rx_is_fragment_i(cls[2]), .rx_csum_bad_i(cls[1]),
    .rx_udp_csum_zero_i(cls[0]), .rx_src_addr_i(src), .station_address_i(48'h0A0B0C0D0E0F),
    .tx_is_udp_lite_i(lite_tx), .rx_drop_o(drop), .tx_lite_csum_gen_o(gen),
    .rx_burst_bytes_o(bytes), .rx_burst_frame_o(frm));
  // Clock at 25 ns
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Program flags, send one classified frame, check the drop pulse
  task automatic drp(input logic [4:0] f, input logic [5:0] c, input logic s, input logic e);
    rcs_host_model_inst.wr(8'h76, {11'h000, f});
    @(posedge core_clk_i) #1;
    cls  = c;
    same = s;
    done = 1'b1;
    @(posedge core_clk_i) #1;
    done = 1'b0;
    cls  = ~c;
    chk({15'h0000, drop}, {15'h0000, e});
  endtask
  // Verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Run limit
  initial begin
    #2500000;
    fails++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_b_i, done, same, lite_tx} = 4'h0;
    {pay, ctl, cls} = 32'h0000_0000;
    repeat (8) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    chk({9'h000, frm, bytes}, 16'h0004);
    rcs_host_model_inst.rd(8'h76, q); chk(q, 16'h0004);
    rcs_host_model_inst.rd(8'h78, q); chk(q, 16'h03E8);
    rcs_host_model_inst.rd(8'h7A, q); chk(q, 16'h0000);
    rcs_host_model_inst.wr(8'h78, 16'hFFFF);
    rcs_host_model_inst.wr(8'h76, 16'hFF9F);
    rcs_host_model_inst.rd(8'h76, q); chk(q, 16'h001F);
    pay = 13'h0064;
    ctl = 13'h0008;
    rcs_host_model_inst.rd(8'h78, q); chk(q, 16'h037C);
    chk({15'h0000, q >= 16'h006C}, 16'h0001);
    pay = 13'h03E0;
    rcs_host_model_inst.rd(8'h78, q); chk(q, 16'h0000);
    pay = 13'h0000;
    // Every burst code 000 to 100
    for (int i = 0; i < 5; i++) begin
      rcs_host_model_inst.wr(8'h76, {8'h00, 3'(i), 5'h04});
      repeat (2) @(posedge core_clk_i);
      #1 chk({9'h000, frm, bytes}, {9'h000, i == 4, bt[i]});
    end
    lite_tx = 1'b1;
    drp(5'h04, 6'h21, 1'b0, 1'b1);
    chk({15'h0000, gen}, 16'h0001);
    drp(5'h08, 6'h21, 1'b0, 1'b0);
    drp(5'h10, 6'h26, 1'b0, 1'b0);
    drp(5'h00, 6'h26, 1'b0, 1'b1);
    chk({15'h0000, gen}, 16'h0000);
    drp(5'h04, 6'h12, 1'b0, 1'b1);
    drp(5'h00, 6'h12, 1'b0, 1'b0);
    drp(5'h02, 6'h0A, 1'b0, 1'b1);
    drp(5'h02, 6'h0E, 1'b0, 1'b0);
    drp(5'h00, 6'h0A, 1'b0, 1'b0);
    drp(5'h01, 6'h00, 1'b1, 1'b1);
    drp(5'h01, 6'h00, 1'b0, 1'b0);
    drp(5'h00, 6'h00, 1'b1, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
